// file: shared/ldl_pkg.sv
// ldl_pkg: opcodes, condition code layout and list header constants
package ldl_pkg;
  // opcodes of the word-load family
  localparam logic [7:0] OP_LOAD_INDEXED = 8'h58;
  localparam logic [7:0] OP_LOAD_REG = 8'h08;
  localparam logic [7:0] OP_LOAD_IMM = 8'hF8;
  localparam logic [7:0] OP_LOAD_SHORT = 8'h24;
  localparam logic [7:0] OP_LOAD_NEG = 8'h25;
  // condition code bit positions (C V G L)
  localparam int CC_C = 3;
  localparam int CC_V = 2;
  localparam int CC_G = 1;
  localparam int CC_L = 0;
  localparam logic [3:0] CC_NONE = 4'h0;
  localparam logic [3:0] CC_POS = 4'h2;
  localparam logic [3:0] CC_NEG = 4'h1;
  // list header: four halfwords, slot 0 follows directly
  localparam int HDR_HALFWORDS = 4;
  localparam logic [17:0] HDR_BYTES = 18'h0_0008;
  localparam int SLOT_SHIFT = 2;
  localparam logic [15:0] SLOT_MAX_COUNT = 16'hFFFF;
  localparam logic [15:0] SLOT_MAX_INDEX = 16'hFFFE;
  // header halfword byte offsets within the list
  localparam logic [2:0] HDR_OFF_TOTAL = 3'h0;
  localparam logic [2:0] HDR_OFF_USED = 3'h2;
  localparam logic [2:0] HDR_OFF_TOP = 3'h4;
  localparam logic [2:0] HDR_OFF_BOTTOM = 3'h6;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
  typedef enum logic [1:0] {
    LDL_ADD_TOP = 2'b00,
    LDL_ADD_BOTTOM = 2'b01,
    LDL_REMOVE_TOP = 2'b11,
    LDL_REMOVE_BOTTOM = 2'b10
  } ldl_list_op_t;
endpackage

// file: shared/ldl_hdr_if.sv
// ldl_hdr_if: list header fields between load unit and header updater
`timescale 1ns/10ps
interface ldl_hdr_if;
  ldl_pkg::ldl_list_op_t op;
  logic [15:0] total;
  logic [15:0] used;
  logic [15:0] top;
  logic [15:0] bottom;
  logic [15:0] new_used;
  logic [15:0] new_top;
  logic [15:0] new_bottom;
  logic [15:0] slot;
  logic empty;
  logic full;
  logic ok;
  modport ctl (output op, total, used, top, bottom,
    input new_used, new_top, new_bottom, slot, empty, full, ok);
  modport upd (input op, total, used, top, bottom,
    output new_used, new_top, new_bottom, slot, empty, full, ok);
endinterface

// file: rtl/ldl_hdr_update.sv
// ldl_hdr_update: next list header values for one add or remove
`timescale 1ns/10ps
module ldl_hdr_update (
  ldl_hdr_if.upd hdr
);
  logic [15:0] last_slot;
  logic [15:0] top_inc;
  logic [15:0] top_dec;
  logic [15:0] bot_inc;
  logic [15:0] bot_dec;
  logic is_add;

  // unsigned halfword compares, slot numbers wrap at total minus one
  assign last_slot = hdr.total - 16'h0001;
  assign top_inc = (hdr.top == last_slot) ? 16'h0000 : hdr.top + 16'h0001;
  assign top_dec = (hdr.top == 16'h0000) ? last_slot : hdr.top - 16'h0001;
  assign bot_inc = (hdr.bottom == last_slot) ? 16'h0000 : hdr.bottom + 16'h0001;
  assign bot_dec = (hdr.bottom == 16'h0000) ? last_slot : hdr.bottom - 16'h0001;
  assign hdr.empty = (hdr.used == 16'h0000);
  assign hdr.full = (hdr.used == hdr.total);
  assign is_add = (hdr.op == ldl_pkg::LDL_ADD_TOP) || (hdr.op == ldl_pkg::LDL_ADD_BOTTOM);
  // zero-slot list is both empty and full, so nothing is ever allowed
  assign hdr.ok = is_add ? !hdr.full : !hdr.empty;

  always_comb begin
    hdr.new_top = hdr.top;
    hdr.new_bottom = hdr.bottom;
    hdr.slot = hdr.top;
    hdr.new_used = is_add ? hdr.used + 16'h0001 : hdr.used - 16'h0001;
    unique case (hdr.op)
      ldl_pkg::LDL_ADD_TOP: begin
        hdr.new_top = top_dec;
        hdr.slot = top_dec;
      end
      ldl_pkg::LDL_ADD_BOTTOM: begin
        hdr.new_bottom = bot_inc;
        hdr.slot = hdr.bottom;
      end
      ldl_pkg::LDL_REMOVE_TOP: begin
        hdr.new_top = top_inc;
        hdr.slot = hdr.top;
      end
      ldl_pkg::LDL_REMOVE_BOTTOM: begin
        hdr.new_bottom = bot_dec;
        hdr.slot = bot_dec;
      end
    endcase
  end
endmodule // ldl_hdr_update

// file: rtl/ldl_load_unit.sv
// ldl_load_unit: word-load execution and circular list header bookkeeping
`timescale 1ns/10ps
// Behaviour
// - header of four halfwords, then slot zero
// - up to 65535 slots, index 0 to FFFE; slot_offset_o for slot FFFE wraps to 0
// - first halfword is total slot count
// - second halfword counts used; zero empty, total full
// - used count incremented on add, decremented remove
// - top and bottom pointers in halfwords three, four
// - accept reg-to-reg, short, indexed and immediate formats
// - word loads copy second operand to destination
// - word load flags: zero none, negative L, positive G
// - same source and destination only tests register
// - short load zero-extends four-bit field
// - short load flags: zero none, else G
// - negated short load writes two's complement
// - negated short flags: zero none, else L
module ldl_load_unit #(
  parameter int DATA_W = 32,
  parameter int REG_W = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // decoder side
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [REG_W-1:0] dest_reg_field_i,
  input wire logic [REG_W-1:0] src_reg_field_i,
  input wire logic [DATA_W-1:0] imm_operand_i,
  input wire logic [DATA_W-1:0] mem_operand_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [DATA_W-1:0] src_reg_data_i,
  // register file and condition code
  output logic reg_we_o,
  output logic [REG_W-1:0] reg_waddr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  output logic [3:0] cond_code_o,
  output logic cc_we_o,
  output logic done_o,
  output logic illegal_op_o,
  output logic misaligned_o,
  // list header bookkeeping
  input wire logic list_valid_i,
  input wire logic [1:0] list_op_i,
  input wire logic [15:0] hdr_total_i,
  input wire logic [15:0] hdr_used_i,
  input wire logic [15:0] hdr_top_i,
  input wire logic [15:0] hdr_bottom_i,
  output logic hdr_we_o,
  output logic [15:0] hdr_used_o,
  output logic [15:0] hdr_top_o,
  output logic [15:0] hdr_bottom_o,
  output logic [17:0] slot_offset_o,
  output logic list_done_o,
  output logic list_empty_o,
  output logic list_full_o,
  output logic list_refused_o
);
  logic is_word_ld;
  logic is_indexed;
  logic is_reg_to_reg;
  logic is_imm_word;
  logic is_short;
  logic is_neg;
  logic known_op;
  logic same_reg;
  logic load_fire;
  logic addr_off_word;
  logic operand_zero;
  logic operand_sign;
  logic [DATA_W-1:0] short_ext;
  logic [DATA_W-1:0] neg_ext;
  logic [DATA_W-1:0] operand;
  logic [3:0] cc_calc;
  logic [17:0] slot_bytes;
  logic [17:0] slot_off;
  // next values of the instruction outputs
  logic reg_we_next;
  logic [REG_W-1:0] reg_waddr_next;
  logic [DATA_W-1:0] reg_wdata_next;
  logic [3:0] cond_code_next;
  logic cc_we_next;
  logic done_next;
  logic illegal_op_next;
  logic misaligned_next;
  // next values of the list outputs
  logic hdr_we_next;
  logic [15:0] hdr_used_next;
  logic [15:0] hdr_top_next;
  logic [15:0] hdr_bottom_next;
  logic list_done_next;
  logic list_empty_next;
  logic list_full_next;
  logic list_refused_next;

  ldl_hdr_if hdr ();

  ldl_hdr_update ldl_hdr_update_inst (
    .hdr(hdr)
  );

  // format decode from the opcode
  assign is_indexed = (opcode_i == ldl_pkg::OP_LOAD_INDEXED);
  assign is_reg_to_reg = (opcode_i == ldl_pkg::OP_LOAD_REG);
  assign is_imm_word = (opcode_i == ldl_pkg::OP_LOAD_IMM);
  assign is_short = (opcode_i == ldl_pkg::OP_LOAD_SHORT);
  assign is_neg = (opcode_i == ldl_pkg::OP_LOAD_NEG);
  assign is_word_ld = is_indexed || is_reg_to_reg || is_imm_word;
  assign known_op = is_word_ld || is_short || is_neg;
  assign same_reg = is_reg_to_reg && (dest_reg_field_i == src_reg_field_i);
  assign load_fire = instr_valid_i && known_op;

  // short operand lives in the source field position
  assign short_ext = {{(DATA_W-REG_W){1'b0}}, src_reg_field_i};
  assign neg_ext = ~short_ext + {{(DATA_W-1){1'b0}}, 1'b1};

  assign operand = is_indexed ? mem_operand_i :
    is_reg_to_reg ? src_reg_data_i :
    is_imm_word ? imm_operand_i :
    is_neg ? neg_ext :
    short_ext;

  // sign bit alone picks L for word loads; short loads are never negative
  assign operand_zero = (operand == '0);
  assign operand_sign = operand[DATA_W-1];
  assign cc_calc = operand_zero ? ldl_pkg::CC_NONE :
    is_neg ? ldl_pkg::CC_NEG :
    is_short ? ldl_pkg::CC_POS :
    operand_sign ? ldl_pkg::CC_NEG : ldl_pkg::CC_POS;

  // a test-only load still updates flags but never writes back
  assign reg_we_next = load_fire && !same_reg;
  assign reg_waddr_next = dest_reg_field_i;
  assign reg_wdata_next = operand;
  assign cond_code_next = load_fire ? cc_calc : cond_code_o;
  assign cc_we_next = load_fire;
  assign done_next = load_fire;
  assign illegal_op_next = instr_valid_i && !known_op;
  // flagged only; alignment is the program's duty, the load still proceeds
  assign addr_off_word = (mem_addr_i[1:0] & ldl_pkg::WORD_ALIGN_MASK) != 2'b00;
  assign misaligned_next = instr_valid_i && is_indexed && addr_off_word;

  // pulses apart from write data so each flop group stays small
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_we_o <= 1'b0;
      cc_we_o <= 1'b0;
      done_o <= 1'b0;
      illegal_op_o <= 1'b0;
      misaligned_o <= 1'b0;
    end else begin
      reg_we_o <= reg_we_next;
      cc_we_o <= cc_we_next;
      done_o <= done_next;
      illegal_op_o <= illegal_op_next;
      misaligned_o <= misaligned_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_waddr_o <= '0;
      reg_wdata_o <= '0;
      cond_code_o <= ldl_pkg::CC_NONE;
    end else begin
      reg_waddr_o <= reg_waddr_next;
      reg_wdata_o <= reg_wdata_next;
      cond_code_o <= cond_code_next;
    end
  end

  // list header path
  assign hdr.op = ldl_pkg::ldl_list_op_t'(list_op_i);
  assign hdr.total = hdr_total_i;
  assign hdr.used = hdr_used_i;
  assign hdr.top = hdr_top_i;
  assign hdr.bottom = hdr_bottom_i;
  // slot n below FFFE sits right after the header, one fullword each; FFFE wraps to offset 0
  assign slot_bytes = {2'b00, hdr.slot} << ldl_pkg::SLOT_SHIFT;
  assign slot_off = ldl_pkg::HDR_BYTES + slot_bytes;

  // refused requests echo the presented header, so a blind write-back is harmless
  assign hdr_we_next = list_valid_i && hdr.ok;
  assign hdr_used_next = hdr.ok ? hdr.new_used : hdr_used_i;
  assign hdr_top_next = hdr.ok ? hdr.new_top : hdr_top_i;
  assign hdr_bottom_next = hdr.ok ? hdr.new_bottom : hdr_bottom_i;
  assign list_done_next = list_valid_i;
  assign list_empty_next = hdr.empty;
  assign list_full_next = hdr.full;
  assign list_refused_next = list_valid_i && !hdr.ok;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hdr_we_o <= 1'b0;
      list_done_o <= 1'b0;
      list_empty_o <= 1'b0;
      list_full_o <= 1'b0;
      list_refused_o <= 1'b0;
    end else begin
      hdr_we_o <= hdr_we_next;
      list_done_o <= list_done_next;
      list_empty_o <= list_empty_next;
      list_full_o <= list_full_next;
      list_refused_o <= list_refused_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hdr_used_o <= '0;
      hdr_top_o <= '0;
      hdr_bottom_o <= '0;
      slot_offset_o <= '0;
    end else begin
      hdr_used_o <= hdr_used_next;
      hdr_top_o <= hdr_top_next;
      hdr_bottom_o <= hdr_bottom_next;
      slot_offset_o <= slot_off;
    end
  end
endmodule // ldl_load_unit

// file: test/ldl_props.sv
// ldl_props: port assertions for the load unit
`timescale 1ns/10ps
module ldl_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [3:0] dest_reg_field_i,
  input wire logic [3:0] src_reg_field_i,
  input wire logic [31:0] imm_operand_i,
  input wire logic reg_we_o,
  input wire logic [31:0] reg_wdata_o,
  input wire logic [3:0] cond_code_o,
  input wire logic cc_we_o,
  input wire logic list_valid_i,
  input wire logic [1:0] list_op_i,
  input wire logic [15:0] hdr_total_i,
  input wire logic [15:0] hdr_used_i,
  input wire logic hdr_we_o,
  input wire logic [15:0] hdr_used_o,
  input wire logic list_refused_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  wire sh_w = instr_valid_i && opcode_i == ldl_pkg::OP_LOAD_SHORT;
  wire ng_w = instr_valid_i && opcode_i == ldl_pkg::OP_LOAD_NEG;
  wire im_w = instr_valid_i && opcode_i == ldl_pkg::OP_LOAD_IMM;
  wire copy_w = instr_valid_i && opcode_i == ldl_pkg::OP_LOAD_REG;
  wire ad_w = list_valid_i && !list_op_i[1];
  wire rm_w = list_valid_i && list_op_i[1];
  wire [31:0] n_w = {28'h000_0000, src_reg_field_i};
  wire [3:0] icc_w = imm_operand_i == 32'h0000_0000 ? 4'h0 : imm_operand_i[31] ? 4'h1 : 4'h2;
  AST_SHORT_DATA: assert property (sh_w |=> reg_wdata_o == $past(n_w))
    else $error("short load data wrong");
  AST_NEG_DATA: assert property (ng_w |=> reg_wdata_o == -$past(n_w))
    else $error("negated load data wrong");
  AST_SHORT_CC: assert property (sh_w |=>
    cond_code_o == ($past(n_w) == 32'h0000_0000 ? 4'h0 : 4'h2))
    else $error("short load flags wrong");
  AST_NEG_CC: assert property (ng_w |=>
    cond_code_o == ($past(n_w) == 32'h0000_0000 ? 4'h0 : 4'h1))
    else $error("negated load flags wrong");
  AST_IMM_DATA: assert property (im_w |=>
    reg_we_o && reg_wdata_o == $past(imm_operand_i))
    else $error("immediate load data wrong");
  AST_WORD_CC: assert property (im_w |=> cc_we_o && cond_code_o == $past(icc_w))
    else $error("word load flags wrong");
  AST_SAME_REG: assert property (copy_w && dest_reg_field_i == src_reg_field_i |=>
    !reg_we_o && cc_we_o)
    else $error("register test wrote");
  AST_FULL_REFUSE: assert property (ad_w && hdr_used_i == hdr_total_i |=>
    list_refused_o && !hdr_we_o)
    else $error("add on full list accepted");
  AST_EMPTY_REFUSE: assert property (rm_w && hdr_used_i == 16'h0000 |=>
    list_refused_o && !hdr_we_o)
    else $error("remove on empty list accepted");
  AST_ADD_COUNT: assert property (ad_w && hdr_used_i != hdr_total_i |=>
    hdr_we_o && hdr_used_o == $past(hdr_used_i) + 16'h0001)
    else $error("add did not count up");
  cover property (copy_w);
  cover property (ng_w);
  cover property (ad_w ##1 list_refused_o);
  cover property (rm_w ##1 hdr_we_o);
endmodule // ldl_props
bind ldl_load_unit ldl_props ldl_props_inst (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .instr_valid_i(instr_valid_i),
  .opcode_i(opcode_i),
  .dest_reg_field_i(dest_reg_field_i),
  .src_reg_field_i(src_reg_field_i),
  .imm_operand_i(imm_operand_i),
  .reg_we_o(reg_we_o),
  .reg_wdata_o(reg_wdata_o),
  .cond_code_o(cond_code_o),
  .cc_we_o(cc_we_o),
  .list_valid_i(list_valid_i),
  .list_op_i(list_op_i),
  .hdr_total_i(hdr_total_i),
  .hdr_used_i(hdr_used_i),
  .hdr_we_o(hdr_we_o),
  .hdr_used_o(hdr_used_o),
  .list_refused_o(list_refused_o)
);

// file: test/ldl_regfile.sv
// ldl_regfile: general register file model feeding the source read port
`timescale 1ns/10ps
module ldl_regfile (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] regs [16];
  // write lands at the edge after the pulse, as a real file would
  always @(posedge clock_i) if (we_i) regs[waddr_i] <= wdata_i;
  assign rdata_o = regs[raddr_i];
endmodule // ldl_regfile

// file: test/ldl_load_unit_tb.sv
// ldl_load_unit_tb: self-checking bench for the load unit
`timescale 1ns/10ps
module ldl_load_unit_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [31:0] exp;
    logic [3:0] cc;
  } ldl_row_t;
  logic clock_i = 0, rst_i = 1, instr_valid_i = 0, list_valid_i = 0;
  logic [7:0] opcode_i = 8'h00;
  logic [3:0] dest_reg_field_i = 4'h0, src_reg_field_i = 4'h0;
  logic [31:0] imm_operand_i = 32'h0000_0000, src_reg_data_i;
  logic [23:0] mem_addr_i = 24'h00_0000;
  logic [1:0] list_op_i = 2'h0;
  logic [15:0] hdr_total_i = 16'h0000, hdr_used_i = 16'h0000;
  logic [15:0] hdr_top_i = 16'h0000, hdr_bottom_i = 16'h0000;
  logic reg_we_o, cc_we_o, done_o, illegal_op_o, misaligned_o, hdr_we_o, list_done_o;
  logic list_empty_o, list_full_o, list_refused_o;
  logic [3:0] reg_waddr_o, cond_code_o;
  logic [31:0] reg_wdata_o;
  logic [15:0] hdr_used_o, hdr_top_o, hdr_bottom_o;
  logic [17:0] slot_offset_o;
  int num_errors = 0, num_checks = 0;
  // indexed and immediate loads take the operand from the exp column; reg-to-reg reads the register file
  ldl_row_t rows [8] = '{
    '{8'h24, 4'h4, 4'hF, 32'h0000_000F, 4'h2},
    '{8'h24, 4'h3, 4'h0, 32'h0000_0000, 4'h0},
    '{8'h25, 4'h8, 4'h7, 32'hFFFF_FFF9, 4'h1},
    '{8'h25, 4'h9, 4'h0, 32'h0000_0000, 4'h0},
    '{8'hF8, 4'h1, 4'h0, 32'h8000_0000, 4'h1},
    '{8'hF8, 4'h2, 4'h0, 32'h0000_0000, 4'h0},
    '{8'h58, 4'h6, 4'h0, 32'h1234_5678, 4'h2},
    '{8'h08, 4'h5, 4'h4, 32'h0000_000F, 4'h2}};
  ldl_load_unit ldl_load_unit_inst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i),
    .dest_reg_field_i(dest_reg_field_i),
    .src_reg_field_i(src_reg_field_i),
    .imm_operand_i(imm_operand_i),
    .mem_operand_i(imm_operand_i),
    .mem_addr_i(mem_addr_i),
    .src_reg_data_i(src_reg_data_i),
    .reg_we_o(reg_we_o),
    .reg_waddr_o(reg_waddr_o),
    .reg_wdata_o(reg_wdata_o),
    .cond_code_o(cond_code_o),
    .cc_we_o(cc_we_o),
    .done_o(done_o),
    .illegal_op_o(illegal_op_o),
    .misaligned_o(misaligned_o),
    .list_valid_i(list_valid_i),
    .list_op_i(list_op_i),
    .hdr_total_i(hdr_total_i),
    .hdr_used_i(hdr_used_i),
    .hdr_top_i(hdr_top_i),
    .hdr_bottom_i(hdr_bottom_i),
    .hdr_we_o(hdr_we_o),
    .hdr_used_o(hdr_used_o),
    .hdr_top_o(hdr_top_o),
    .hdr_bottom_o(hdr_bottom_o),
    .slot_offset_o(slot_offset_o),
    .list_done_o(list_done_o),
    .list_empty_o(list_empty_o),
    .list_full_o(list_full_o),
    .list_refused_o(list_refused_o)
  );
  ldl_regfile ldl_regfile_inst (.clock_i(clock_i), .we_i(reg_we_o), .waddr_i(reg_waddr_o),
    .wdata_i(reg_wdata_o), .raddr_i(src_reg_field_i), .rdata_o(src_reg_data_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic issue(input ldl_row_t r);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    opcode_i <= r.op;
    dest_reg_field_i <= r.dst;
    src_reg_field_i <= r.src;
    imm_operand_i <= r.exp;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic lst(input logic [1:0] op, input logic [15:0] t, u, tp, b);
    @(posedge clock_i);
    list_valid_i <= 1'b1;
    list_op_i <= op;
    hdr_total_i <= t;
    hdr_used_i <= u;
    hdr_top_i <= tp;
    hdr_bottom_i <= b;
    @(posedge clock_i);
    list_valid_i <= 1'b0;
    #1;
  endtask
  initial forever #4 clock_i = ~clock_i;
  initial begin
    #20000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk({done_o, cond_code_o}, 5'h00);
    foreach (rows[i]) begin
      issue(rows[i]);
      chk(reg_wdata_o, rows[i].exp);
      chk(cond_code_o, rows[i].cc);
      chk({reg_we_o, done_o, reg_waddr_o}, {2'h3, rows[i].dst});
    end
    issue('{8'h08, 4'h4, 4'h4, 32'h0000_0000, 4'h0});
    chk({reg_we_o, cc_we_o, cond_code_o}, 6'h12);
    issue('{8'h00, 4'h4, 4'h1, 32'h8000_0000, 4'h0});
    chk({illegal_op_o, done_o, cc_we_o, cond_code_o}, 7'h42);
    @(posedge clock_i);
    mem_addr_i <= 24'h00_0002;
    issue(rows[6]);
    chk({misaligned_o, done_o, reg_wdata_o == 32'h1234_5678}, 3'h7);
    @(posedge clock_i);
    mem_addr_i <= 24'h00_0000;
    lst(2'h1, 16'h0004, 16'h0000, 16'h0000, 16'h0000);
    chk({hdr_we_o, list_done_o, list_empty_o, hdr_bottom_o}, {3'h7, 16'h0001});
    chk(hdr_used_o, 32'h0000_0001);
    chk(slot_offset_o, 32'h0000_0008);
    lst(2'h0, 16'h0004, 16'h0004, 16'h0001, 16'h0001);
    chk({list_refused_o, hdr_we_o, list_full_o}, 3'h5);
    // removing the last slot wraps the top pointer back to slot zero
    lst(2'h3, 16'h0003, 16'h0001, 16'h0002, 16'h0000);
    chk({hdr_used_o, hdr_top_o}, 32'h0000_0000);
    chk(slot_offset_o, 32'h0000_0010);
    // removing from the bottom below slot zero wraps to the last slot
    lst(2'h2, 16'h0004, 16'h0002, 16'h0002, 16'h0000);
    chk({hdr_used_o, hdr_bottom_o}, 32'h0001_0003);
    chk(slot_offset_o, 32'h0000_0014);
    // remove on an empty list leaves the header as presented
    lst(2'h3, 16'h0004, 16'h0000, 16'h0001, 16'h0001);
    chk({list_refused_o, hdr_we_o, list_empty_o, list_done_o, hdr_top_o}, {4'hB, 16'h0001});
    lst(2'h0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0001);
    chk({hdr_used_o, hdr_top_o}, 32'h0002_FFFE);
    test_done();
  end
endmodule // ldl_load_unit_tb
